// ---- core/adc_seq_map.svh ----
// Function
// R1: Route one of eight inputs through the multiplexer, convert by 8-bit successive approximation.
// R2: Sample the selected channel during the first five machine cycles.
// R3: Hold the sample for the rest of a roughly ten microsecond conversion.
// R4: Offer single-shot and continuous conversion modes.
// R5: Each finished conversion can raise the interrupt.
// R6: Upper and lower internal references each take a 4-bit, 16-step code.
// R7: Range register: low nibble lower reference, high nibble upper reference.
// R8: Any range register write loads both references and starts a conversion; the code ignores a range write with wb_sel_i[0] low.
// R9: Software may pick a new range before converting each channel.
// R10: Ten-bit sequence begins with a coarse conversion over the full span.
// R11: Coarse top bits locate the signal within the span.
// R12: Then program the narrow range and convert again for the lower bits.
// R13: Seven overlapping sub-ranges; even ones start half a range higher.
// R14: Odd sub-range: fine result is taken unchanged as low eight bits.
// R15: Even sub-range: add 80H, carry goes into the upper two bits.
// R16: Coarse upper nibble indexes a table giving the fine range value.
// R17: Table value bit 1 marks even; bits 3:2 give upper result bits.
// R18: Wait for coarse end before narrowing; flag the result with a pulse.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_RANGE 8'h00
`define REG_CTRL 8'h04
`define REG_DATA 8'h08
`define REG_RESULT 8'h0c
`define REG_STATUS 8'h10
`define REG_MASK 8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_CH_MSB 2
`define CTRL_CH_LSB 0
`define CTRL_CONT 3
`define CTRL_START10 4
`define RANGE_UP_MSB 7
`define RANGE_UP_LSB 4
`define RANGE_LO_MSB 3
`define RANGE_LO_LSB 0
`define RANGE_RST 8'h00
`define RANGE_FULL 8'h00
`define ST_CONV 0
`define ST_TEN 1
`define FINE_EVEN_BIT 1
`define FINE_MSB_HI 3
`define FINE_MSB_LO 2
`define EVEN_OFFSET 9'h080
`define SAR_MSB_INIT 8'h80
`define SAR_LSB 8'h01
`define SAR_TOP 3'h7
`define SAMPLE_LAST 3'h4

// ----------------------------------------
// Sub-range table entries
// ----------------------------------------
`define SUB1 8'h40
`define SUB2 8'h62
`define SUB3 8'h84
`define SUB4 8'ha6
`define SUB5 8'hc8
`define SUB6 8'hea
`define SUB7 8'h0c

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 125
`define MC_NS 1000
`define TRIAL_NS 625
`define MC_CYC ((`MC_NS * `CLK_MHZ + 999) / 1000)
`define TRIAL_CYC ((`TRIAL_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- core/adc_seq_pkg.sv ----
package adc_seq_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_SAMPLE = 2'b01,
        CV_TRIAL = 2'b10
    } conv_state_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_COARSE = 2'b01,
        SQ_FINE = 2'b10
    } seq_state_t;

endpackage

// ---- core/two_step_subrange_adc_sequencer.sv ----
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module two_step_subrange_adc_sequencer (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire adc_seq_pkg::word_t wb_dat_i,
    output adc_seq_pkg::word_t wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic cmp_i,
    output logic [2:0] mux_sel_o,
    output logic [3:0] upper_ref_o,
    output logic [3:0] lower_ref_o,
    output logic sample_o,
    output logic [7:0] sar_code_o,
    output logic busy_o,
    output logic [9:0] result10_o,
    output logic ten_done_o
);
    import adc_seq_pkg::*;

    // ----------------------------------------
    // Declarations and timing counts
    // ----------------------------------------
    localparam logic [7:0] MC_CYC = 8'(`MC_CYC);
    localparam logic [7:0] TRIAL_CYC = 8'(`TRIAL_CYC);
    logic ack_r;
    word_t dat_r;
    word_t rd_nxt;
    logic req;
    logic wr_fire;
    logic rd_fire;
    logic range_wr;
    logic ctrl_wr;
    logic mask_wr;
    logic status_rd;
    logic start10;
    logic [7:0] range_r;
    logic [2:0] chan_r;
    logic cont_r;
    logic [1:0] status_r;
    logic [1:0] status_nxt;
    logic [1:0] mask_r;
    logic irq_r;
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic cmp_s3_r;
    logic cmp_r;
    conv_state_t conv_r;
    logic [7:0] div_r;
    logic [7:0] div_lim;
    logic tick;
    logic [2:0] bit_r;
    logic [7:0] sar_r;
    logic [7:0] sar_kept;
    logic [7:0] data_r;
    logic conv_done_r;
    logic sample_r;
    logic busy_r;
    logic [2:0] mux_r;
    logic start_conv;
    seq_state_t seq_r;
    logic seq_load;
    logic [7:0] seq_val;
    logic seq_fin;
    logic [7:0] fine_range_r;
    logic [8:0] fine_sum;
    logic [1:0] fine_msb;
    logic [9:0] res10_r;
    logic ten_done_r;

    // ----------------------------------------
    // Sub-range lookup
    // ----------------------------------------
    function automatic logic [7:0] sub_lut(input logic [3:0] nib);
        logic [7:0] val;
        val = `SUB1;
        case (nib)
            4'h0, 4'h1: val = `SUB1;
            4'h2, 4'h3: val = `SUB2;
            4'h4, 4'h5: val = `SUB3;
            4'h6, 4'h7: val = `SUB4;
            4'h8, 4'h9: val = `SUB5;
            4'ha, 4'hb: val = `SUB6;
            default: val = `SUB7;
        endcase
        return val;
    endfunction

    // ----------------------------------------
    // Wishbone decode
    // ----------------------------------------
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_we_i & ack_r & wb_sel_i[0];
    assign rd_fire = req & ~wb_we_i & ack_r;
    assign range_wr = wr_fire & (wb_adr_i == `REG_RANGE);
    assign ctrl_wr = wr_fire & (wb_adr_i == `REG_CTRL);
    assign mask_wr = wr_fire & (wb_adr_i == `REG_MASK);
    assign status_rd = rd_fire & (wb_adr_i == `REG_STATUS);
    assign start10 = ctrl_wr & wb_dat_i[`CTRL_START10];

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_comb begin
        rd_nxt = '0;
        case (wb_adr_i)
            `REG_RANGE: rd_nxt[7:0] = range_r;
            `REG_CTRL: begin
                rd_nxt[`CTRL_CH_MSB:`CTRL_CH_LSB] = chan_r;
                rd_nxt[`CTRL_CONT] = cont_r;
                rd_nxt[`CTRL_START10] = (seq_r != SQ_IDLE);
            end
            `REG_DATA: rd_nxt[7:0] = data_r;
            `REG_RESULT: rd_nxt[9:0] = res10_r;
            `REG_STATUS: rd_nxt[1:0] = status_r;
            `REG_MASK: rd_nxt[1:0] = mask_r;
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dat_r <= '0;
        end else if (req & ~ack_r) begin
            dat_r <= rd_nxt;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            chan_r <= '0;
            cont_r <= 1'b0;
        end else if (ctrl_wr) begin
            chan_r <= wb_dat_i[`CTRL_CH_MSB:`CTRL_CH_LSB]; // R9
            cont_r <= wb_dat_i[`CTRL_CONT]; // R4
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mask_r <= '0;
        end else if (mask_wr) begin
            mask_r <= wb_dat_i[1:0];
        end
    end

    // Bus write wins over the sequencer's own load
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            range_r <= `RANGE_RST;
        end else if (range_wr) begin
            range_r <= wb_dat_i[7:0]; // R8
        end else if (seq_load) begin
            range_r <= seq_val; // R12
        end
    end

    // ----------------------------------------
    // Comparator synchroniser
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
            cmp_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_i;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
            if (cmp_s2_r == cmp_s3_r) begin
                cmp_r <= cmp_s3_r;
            end
        end
    end

    // ----------------------------------------
    // Conversion start and phase divider
    // ----------------------------------------
    assign start_conv = range_wr | seq_load | (conv_done_r & cont_r & (seq_r == SQ_IDLE)); // R4
    assign div_lim = (conv_r == CV_SAMPLE) ? MC_CYC : TRIAL_CYC;
    assign tick = (conv_r != CV_IDLE) & (div_r == div_lim - 8'h01);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            div_r <= '0;
        end else if (start_conv | tick | (conv_r == CV_IDLE)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // ----------------------------------------
    // Successive approximation
    // ----------------------------------------
    // Trial bit stays only when the input lies at or above the trial level
    assign sar_kept = cmp_r ? sar_r : (sar_r & ~(`SAR_LSB << bit_r));

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            conv_r <= CV_IDLE;
            bit_r <= '0;
            sar_r <= '0;
            data_r <= '0;
            conv_done_r <= 1'b0;
            sample_r <= 1'b0;
            busy_r <= 1'b0;
            mux_r <= '0;
        end else begin
            conv_done_r <= 1'b0;
            if (start_conv) begin
                conv_r <= CV_SAMPLE;
                bit_r <= '0;
                sar_r <= '0;
                sample_r <= 1'b1; // R2
                busy_r <= 1'b1;
                mux_r <= ctrl_wr ? wb_dat_i[`CTRL_CH_MSB:`CTRL_CH_LSB] : chan_r; // R1
            end else begin
                case (conv_r)
                    CV_SAMPLE: begin
                        if (tick) begin
                            if (bit_r == `SAMPLE_LAST) begin
                                conv_r <= CV_TRIAL;
                                sample_r <= 1'b0; // R3
                                bit_r <= `SAR_TOP;
                                sar_r <= `SAR_MSB_INIT;
                            end else begin
                                bit_r <= bit_r + 3'h1; // R2
                            end
                        end
                    end
                    CV_TRIAL: begin
                        if (tick) begin
                            if (bit_r == 3'h0) begin
                                conv_r <= CV_IDLE;
                                sar_r <= sar_kept; // R1
                                data_r <= sar_kept;
                                conv_done_r <= 1'b1; // R5
                                busy_r <= 1'b0;
                            end else begin
                                sar_r <= sar_kept | (`SAR_LSB << (bit_r - 3'h1)); // R1
                                bit_r <= bit_r - 3'h1;
                            end
                        end
                    end
                    default: begin
                        conv_r <= CV_IDLE;
                        busy_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Ten-bit sequencer
    // ----------------------------------------
    always_comb begin
        seq_load = 1'b0;
        seq_val = `RANGE_FULL;
        seq_fin = 1'b0;
        case (seq_r)
            SQ_IDLE: seq_load = start10 & ~range_wr; // R10
            SQ_COARSE: begin
                if (conv_done_r & ~range_wr) begin
                    seq_load = 1'b1; // R18
                    seq_val = sub_lut(data_r[7:4]); // R16
                end
            end
            SQ_FINE: seq_fin = conv_done_r & ~range_wr;
            default: seq_load = 1'b0;
        endcase
    end

    assign fine_sum = {1'b0, data_r} + (`EVEN_OFFSET & {9{fine_range_r[`FINE_EVEN_BIT]}}); // R15
    assign fine_msb = fine_range_r[`FINE_MSB_HI:`FINE_MSB_LO] + {1'b0, fine_sum[8]}; // R17

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            seq_r <= SQ_IDLE;
            fine_range_r <= `RANGE_FULL;
        end else if (range_wr) begin
            seq_r <= SQ_IDLE;
        end else begin
            case (seq_r)
                SQ_IDLE: begin
                    if (start10) begin
                        seq_r <= SQ_COARSE; // R10
                    end
                end
                SQ_COARSE: begin
                    if (conv_done_r) begin
                        seq_r <= SQ_FINE; // R18
                        fine_range_r <= seq_val; // R13
                    end
                end
                SQ_FINE: begin
                    if (conv_done_r) begin
                        seq_r <= SQ_IDLE;
                    end
                end
                default: seq_r <= SQ_IDLE;
            endcase
        end
    end

    // Odd sub-range adds nothing, so the fine code passes unchanged
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            res10_r <= '0;
            ten_done_r <= 1'b0;
        end else begin
            ten_done_r <= seq_fin; // R18
            if (seq_fin) begin
                res10_r <= {fine_msb, fine_sum[7:0]}; // R11 R14 R15
            end
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    // New events win over the clearing read
    always_comb begin
        status_nxt = status_r & ~{2{status_rd}};
        status_nxt[`ST_CONV] = status_nxt[`ST_CONV] | conv_done_r; // R5
        status_nxt[`ST_TEN] = status_nxt[`ST_TEN] | seq_fin;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            status_r <= '0;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask_r); // R5
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o = irq_r;
    assign mux_sel_o = mux_r;
    assign upper_ref_o = range_r[`RANGE_UP_MSB:`RANGE_UP_LSB]; // R6 R7
    assign lower_ref_o = range_r[`RANGE_LO_MSB:`RANGE_LO_LSB]; // R6 R7
    assign sample_o = sample_r;
    assign sar_code_o = sar_r;
    assign busy_o = busy_r;
    assign result10_o = res10_r;
    assign ten_done_o = ten_done_r;

endmodule

// ---- testbench/adc_seq_monitor.sv ----
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module adc_seq_monitor (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire adc_seq_pkg::word_t wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [2:0] mux_sel_o,
    input wire logic [3:0] upper_ref_o,
    input wire logic [3:0] lower_ref_o,
    input wire logic sample_o,
    input wire logic [7:0] sar_code_o,
    input wire logic busy_o,
    input wire logic [9:0] result10_o,
    input wire logic ten_done_o
);
    import adc_seq_pkg::*;
    localparam int SAMPLE_CYC = 5 * `MC_CYC;
    localparam int CONV_CYC = SAMPLE_CYC + 8 * `TRIAL_CYC;
    logic rng_wr;
    logic [7:0] wr_byte_r;
    int samp_cnt_r;
    int busy_cnt_r;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // ----------------------------------------
    // Phase counters, restarted by a range write
    // ----------------------------------------
    assign rng_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
        && wb_adr_i == `REG_RANGE;

    always_ff @(posedge mclk_i) begin
        if (rng_wr) begin
            wr_byte_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i || rng_wr) begin
            samp_cnt_r <= 0;
            busy_cnt_r <= 0;
        end else begin
            samp_cnt_r <= sample_o ? samp_cnt_r + 1 : 0;
            busy_cnt_r <= busy_o ? busy_cnt_r + 1 : 0;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    chk_range_loads_refs: assert property (
        rng_wr |=> {upper_ref_o, lower_ref_o} == wr_byte_r && sample_o && busy_o)
        else $error("range write did not load references and start");
    chk_ref_change_starts: assert property (
        $changed({upper_ref_o, lower_ref_o}) |-> sample_o && busy_o)
        else $error("reference change without a conversion start");
    chk_sample_length: assert property ($fell(sample_o) |-> samp_cnt_r == SAMPLE_CYC)
        else $error("sampling phase has wrong length");
    chk_conv_length: assert property ($fell(busy_o) |-> busy_cnt_r == CONV_CYC)
        else $error("conversion has wrong length");
    chk_msb_first: assert property ($fell(sample_o) |-> sar_code_o == `SAR_MSB_INIT)
        else $error("first trial is not the top bit");
    chk_channel_held: assert property (busy_o && !sample_o |-> $stable(mux_sel_o))
        else $error("channel moved after sampling");
    chk_done_pulse: assert property (ten_done_o |=> !ten_done_o)
        else $error("ten-bit done longer than one cycle");
    chk_result_update: assert property ($changed(result10_o) |-> ten_done_o)
        else $error("ten-bit result changed without done");
    chk_done_after_fine: assert property (
        ten_done_o |-> !busy_o && !$past(busy_o) && $past(busy_o, 2))
        else $error("ten-bit done not one cycle after fine end");

    cov_range_write: cover property (rng_wr);
    cov_ten_done: cover property (ten_done_o);
    cov_conv_end: cover property ($fell(busy_o));
endmodule

bind two_step_subrange_adc_sequencer adc_seq_monitor mon (
    .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .mux_sel_o(mux_sel_o), .upper_ref_o(upper_ref_o),
    .lower_ref_o(lower_ref_o), .sample_o(sample_o), .sar_code_o(sar_code_o),
    .busy_o(busy_o), .result10_o(result10_o), .ten_done_o(ten_done_o)
);

// ---- testbench/analog_source_model.sv ----
`timescale 1ns/1ps

module analog_source_model (
    input wire logic mclk_i,
    input wire logic [2:0] mux_sel_i,
    input wire logic sample_i,
    input wire logic [3:0] upper_ref_i,
    input wire logic [3:0] lower_ref_i,
    input wire logic [7:0] sar_code_i,
    output logic cmp_o
);
    // ----------------------------------------
    // Channel levels in 5 mV steps of the span
    // ----------------------------------------
    logic [9:0] lvl [8];
    logic [9:0] held_r = 10'h000;
    int hi;
    int lo;

    initial begin
        foreach (lvl[i]) begin
            lvl[i] = 10'h000;
        end
    end

    // Tracks while sampling, frozen afterwards
    always @(posedge mclk_i) begin
        if (sample_i) begin
            held_r <= lvl[mux_sel_i];
        end
    end

    // Upper code zero is the top of the span
    assign hi = (upper_ref_i == 4'h0) ? 1024 : 64 * int'(upper_ref_i);
    assign lo = 64 * int'(lower_ref_i);
    assign cmp_o = 256 * int'(held_r) >= 256 * lo + (hi - lo) * int'(sar_code_i);
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module tb;
    import adc_seq_pkg::*;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    word_t wb_dat_i = 32'h0;
    word_t wb_dat_o;
    word_t rd;
    logic wb_ack_o, irq_o, cmp_i, sample_o, busy_o, ten_done_o;
    logic [2:0] mux_sel_o;
    logic [3:0] upper_ref_o, lower_ref_o;
    logic [7:0] sar_code_o;
    logic [9:0] result10_o, v;
    int fail_count = 0;
    int n_compared = 0;

    two_step_subrange_adc_sequencer DUT (
        .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .cmp_i(cmp_i),
        .mux_sel_o(mux_sel_o), .upper_ref_o(upper_ref_o), .lower_ref_o(lower_ref_o),
        .sample_o(sample_o), .sar_code_o(sar_code_o), .busy_o(busy_o),
        .result10_o(result10_o), .ten_done_o(ten_done_o)
    );

    analog_source_model src (
        .mclk_i(mclk_i), .mux_sel_i(mux_sel_o), .sample_i(sample_o),
        .upper_ref_i(upper_ref_o), .lower_ref_i(lower_ref_o), .sar_code_i(sar_code_o),
        .cmp_o(cmp_i)
    );

    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    // ----------------------------------------
    // Bus and checking tasks
    // ----------------------------------------
    task automatic check(input word_t seen, input word_t exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input word_t d, input logic [3:0] s);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input word_t d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input logic [7:0] a, input word_t exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(rd, exp);
    endtask

    task automatic wait_sig(input int sel, input logic lvl);
        do @(negedge mclk_i); while ((sel == 0 ? busy_o : sel == 1 ? sample_o : ten_done_o) !== lvl);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk_i);
        fail_count++;
        tally_and_finish;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd_chk(`REG_RANGE, 32'h0);
        rd_chk(8'h20, 32'h0);
        src.lvl[3] = 10'd500;
        wr(`REG_MASK, 32'h1);
        wr(`REG_CTRL, 32'h3);
        wr(`REG_RANGE, 32'hc4);
        wait_sig(1, 1'b0);
        check(word_t'({mux_sel_o, upper_ref_o, lower_ref_o}), 32'h3c4);
        src.lvl[3] = 10'd900;
        wait_sig(0, 1'b0);
        rd_chk(`REG_DATA, 32'h7a);
        check(word_t'(irq_o), 32'h1);
        rd_chk(`REG_STATUS, 32'h1);
        repeat (2) @(negedge mclk_i);
        check(word_t'(irq_o), 32'h0);
        bus(1'b1, `REG_RANGE, 32'h40, 4'h0);
        @(negedge mclk_i);
        check(word_t'({busy_o, upper_ref_o, lower_ref_o}), 32'hc4);
        // Continuous conversions, masked interrupt
        wr(`REG_MASK, 32'h0);
        src.lvl[0] = 10'd400;
        wr(`REG_CTRL, 32'h8);
        wr(`REG_RANGE, 32'h0);
        wait_sig(0, 1'b0);
        repeat (3) @(negedge mclk_i);
        check(word_t'(busy_o), 32'h1);
        wr(`REG_CTRL, 32'h0);
        wait_sig(0, 1'b0);
        repeat (3) @(negedge mclk_i);
        check(word_t'({busy_o, irq_o}), 32'h0);
        rd_chk(`REG_DATA, 32'h64);
        rd_chk(`REG_STATUS, 32'h1);
        // Ten-bit sequence through every table entry
        for (int n = 0; n < 16; n++) begin
            v = 10'(64 * n + 37);
            src.lvl[n % 8] = v;
            wr(`REG_CTRL, word_t'(32'h10 | n % 8));
            wait_sig(2, 1'b1);
            check(word_t'(result10_o), word_t'(v));
        end
        rd_chk(`REG_RESULT, word_t'(v));
        // Even sub-range whose offset carries into the top bits
        src.lvl[5] = 10'd255;
        wr(`REG_CTRL, 32'h15);
        wait_sig(0, 1'b0);
        src.lvl[5] = 10'd300;
        wait_sig(2, 1'b1);
        check(word_t'(result10_o), 32'h12c);
        rd_chk(`REG_STATUS, 32'h3);
        // Range write aborts a running sequence
        wr(`REG_CTRL, 32'h12);
        wait_sig(1, 1'b0);
        wr(`REG_RANGE, 32'h0);
        wait_sig(0, 1'b0);
        rd_chk(`REG_CTRL, 32'h2);
        rd_chk(`REG_STATUS, 32'h1);
        // Reset in mid-conversion
        wr(`REG_RANGE, 32'h84);
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(negedge mclk_i);
        check(word_t'({busy_o, sample_o, upper_ref_o, lower_ref_o}), 32'h0);
        rd_chk(`REG_RANGE, 32'h0);
        tally_and_finish;
    end
endmodule
